// [core/spdp_params.svh]
`ifndef SPDP_PARAMS_SVH
`define SPDP_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SPDP_OFF_CMD    8'h00
`define SPDP_OFF_STAT   8'h04
`define SPDP_OFF_SP     8'h08
`define SPDP_OFF_DPL    8'h0c
`define SPDP_OFF_DPH    8'h10
`define SPDP_OFF_ACC    8'h14
`define SPDP_OFF_R0     8'h18
`define SPDP_OFF_R1     8'h1c
`define SPDP_OFF_RET    8'h20

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define SPDP_OP_MSB     3
`define SPDP_OP_LSB     0
`define SPDP_DIR_MSB    15
`define SPDP_DIR_LSB    8
`define SPDP_IMM_MSB    31
`define SPDP_IMM_LSB    16

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SPDP_OP_NOP     4'h0
`define SPDP_OP_PUSH    4'h1
`define SPDP_OP_POP     4'h2
`define SPDP_OP_CALL    4'h3
`define SPDP_OP_RET     4'h4
`define SPDP_OP_INT     4'h5
`define SPDP_OP_INTERRUPT_RETURN    4'h6
`define SPDP_OP_LDDP    4'h7
`define SPDP_OP_XRD_DP  4'h8
`define SPDP_OP_XRD_R0  4'h9
`define SPDP_OP_XRD_R1  4'ha
`define SPDP_OP_XWR_DP  4'hb
`define SPDP_OP_XWR_R0  4'hc
`define SPDP_OP_XWR_R1  4'hd

// ----------------------------------------------------------------
// Direct addresses of special registers (at or above SFR base)
// ----------------------------------------------------------------
`define SPDP_SFR_BASE   8'h80
`define SPDP_SFR_SP     8'h81
`define SPDP_SFR_DPL    8'h82
`define SPDP_SFR_DPH    8'h83
`define SPDP_SFR_ACC    8'he0

// ----------------------------------------------------------------
// Reset values, constants, timing
// ----------------------------------------------------------------
`define SPDP_SP_RESET   8'h07
`define SPDP_BYTE_ZERO  8'h00
`define SPDP_HSIZE_WORD 3'b010
`define SPDP_DATA_ADDRESS_POINTER_CYC   2'd2
`define SPDP_STAT_BUSY  0
`define SPDP_STAT_ISR   1
`define SPDP_STAT_XREQ  2

`endif

// [core/spdp_pkg.sv]
package spdp_pkg;

  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_PUSH_INC = 8'h02,
    ST_PUSH_WR  = 8'h04,
    ST_POP      = 8'h08,
    ST_DATA_ADDRESS_POINTER     = 8'h10,
    ST_EXT_REQ  = 8'h20,
    ST_EXT_REL  = 8'h40
  } spdp_state_t;

  typedef logic [7:0] spdp_byte_t;

endpackage : spdp_pkg

// [core/spdp_ram.sv]
`timescale 1ns/1ps

module spdp_ram #(
  parameter int ADDR_W = 8,
  parameter int DEPTH  = 256
) (
  input  wire logic              hclk,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [7:0]        rdata,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [7:0]        wdata
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DEPTH != (1 << ADDR_W)) begin : g_bad_depth
    $error("spdp_ram depth must equal two to the address width");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem [DEPTH];

  // Asynchronous read port
  assign rdata = mem[raddr];

  // Synchronous write port
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

endmodule : spdp_ram

// [core/spdp_core.sv]
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "spdp_params.svh"

module spdp_core #(
  parameter int RAM_AW = 8
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic      [15:0]           ext_addr,
  output logic      [7:0]            ext_wdata,
  output logic                       ext_req,
  output logic                       ext_we,
  input  wire spdp_pkg::spdp_byte_t  ext_rdata,
  input  wire logic                  ext_ack
);
  import spdp_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (RAM_AW != 8) begin : g_bad_aw
    $error("spdp_core serves an 8-bit stack index only");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  spdp_state_t state_reg;
  logic [7:0]  sp_reg;
  logic [7:0]  dpl_reg;
  logic [7:0]  dph_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  r0_reg;
  logic [7:0]  r1_reg;
  logic [15:0] ret_reg;
  logic [31:0] cmd_reg;
  logic        isr_reg;
  logic        byte_reg;
  logic [7:0]  hold_reg;
  logic [1:0]  wait_reg;
  logic        ap_wr_reg;
  logic [7:0]  ap_addr_reg;
  logic [31:0] hrdata_reg;
  logic        ack_s1_reg;
  logic        ack_s2_reg;
  logic [7:0]  rdat_s1_reg;
  logic [7:0]  rdat_s2_reg;
  logic [15:0] ext_addr_reg;
  logic [7:0]  ext_wdata_reg;
  logic        ext_req_reg;
  logic        ext_we_reg;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Wrapping index step, no overflow detection
  function automatic logic [7:0] step(input logic [7:0] v, input logic up);
    step = up ? 8'(v + 8'h01) : 8'(v - 8'h01);
  endfunction : step

  // Direct address below the special register range
  function automatic logic is_ram(input logic [7:0] d);
    is_ram = (d < `SPDP_SFR_BASE);
  endfunction : is_ram

  // Special register read by direct address
  function automatic logic [7:0] sfr_rd(input logic [7:0] d);
    unique case (d)
      `SPDP_SFR_SP:  sfr_rd = sp_reg;
      `SPDP_SFR_DPL: sfr_rd = dpl_reg;
      `SPDP_SFR_DPH: sfr_rd = dph_reg;
      `SPDP_SFR_ACC: sfr_rd = acc_reg;
      default:       sfr_rd = `SPDP_BYTE_ZERO;
    endcase
  endfunction : sfr_rd

  // Two-byte stack operations
  function automatic logic is_pair(input logic [3:0] o);
    is_pair = (o == `SPDP_OP_CALL) || (o == `SPDP_OP_RET) ||
              (o == `SPDP_OP_INT) || (o == `SPDP_OP_INTERRUPT_RETURN);
  endfunction : is_pair

  // ----------------------------------------------------------------
  // Field extraction and bus decode
  // ----------------------------------------------------------------
  logic [3:0]  op;
  logic [7:0]  dir;
  logic [15:0] imm;
  logic [3:0]  new_op;
  logic        ap_take;
  logic        wr_ok;
  logic        start;

  assign op      = cmd_reg[`SPDP_OP_MSB:`SPDP_OP_LSB];
  assign dir     = cmd_reg[`SPDP_DIR_MSB:`SPDP_DIR_LSB];
  assign imm     = cmd_reg[`SPDP_IMM_MSB:`SPDP_IMM_LSB];
  assign new_op  = hwdata[`SPDP_OP_MSB:`SPDP_OP_LSB];
  assign ap_take = hsel && htrans[1] && hready && (hsize == `SPDP_HSIZE_WORD);
  assign wr_ok   = ap_wr_reg && (state_reg == ST_IDLE);
  assign start   = wr_ok && (ap_addr_reg == `SPDP_OFF_CMD);

  // Pointer bytes presented as one address
  logic [15:0] data_address_pointer;
  assign data_address_pointer = {dph_reg, dpl_reg};

  // ----------------------------------------------------------------
  // On-chip RAM, sole home of the stack
  // ----------------------------------------------------------------
  logic [7:0] ram_raddr;
  logic [7:0] ram_rdata;
  logic       ram_we;
  logic [7:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [7:0] push_byte;
  logic       pop_to_sfr;

  // Read port: push source in increment cycle, else top of stack
  assign ram_raddr = (state_reg == ST_PUSH_INC) ? dir : sp_reg;

  // Write port: push store, or pop into direct RAM location
  always_comb begin
    ram_we    = 1'b0;
    ram_waddr = sp_reg;
    ram_wdata = hold_reg;
    if (state_reg == ST_PUSH_WR) begin
      ram_we = 1'b1;
    end else if (state_reg == ST_POP && op == `SPDP_OP_POP && is_ram(dir)) begin
      ram_we    = 1'b1;
      ram_waddr = dir;
      ram_wdata = ram_rdata;
    end
  end

  // Byte to push: direct operand or half of return address
  always_comb begin
    if (op == `SPDP_OP_PUSH) begin
      push_byte = is_ram(dir) ? ram_rdata : sfr_rd(dir);
    end else begin
      push_byte = byte_reg ? imm[15:8] : imm[7:0];
    end
  end

  assign pop_to_sfr = (state_reg == ST_POP) && (op == `SPDP_OP_POP) && !is_ram(dir);

  spdp_ram #(
    .ADDR_W (RAM_AW),
    .DEPTH  (1 << RAM_AW)
  ) u_ram (
    .hclk  (hclk),
    .raddr (ram_raddr),
    .rdata (ram_rdata),
    .we    (ram_we),
    .waddr (ram_waddr),
    .wdata (ram_wdata)
  );

  // ----------------------------------------------------------------
  // External pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_s1_reg  <= 1'b0;
      ack_s2_reg  <= 1'b0;
      rdat_s1_reg <= `SPDP_BYTE_ZERO;
      rdat_s2_reg <= `SPDP_BYTE_ZERO;
    end else begin
      ack_s1_reg  <= ext_ack;
      ack_s2_reg  <= ack_s1_reg;
      rdat_s1_reg <= ext_rdata;
      rdat_s2_reg <= rdat_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      byte_reg  <= 1'b0;
      wait_reg  <= 2'd0;
      hold_reg  <= `SPDP_BYTE_ZERO;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          byte_reg <= 1'b0;
          if (start) begin
            unique case (new_op)
              `SPDP_OP_PUSH, `SPDP_OP_CALL, `SPDP_OP_INT: state_reg <= ST_PUSH_INC;
              `SPDP_OP_POP, `SPDP_OP_RET, `SPDP_OP_INTERRUPT_RETURN:  state_reg <= ST_POP;
              `SPDP_OP_LDDP: begin
                state_reg <= ST_DATA_ADDRESS_POINTER;
                wait_reg  <= 2'(`SPDP_DATA_ADDRESS_POINTER_CYC - 2'd1);
              end
              `SPDP_OP_XRD_DP, `SPDP_OP_XRD_R0, `SPDP_OP_XRD_R1,
              `SPDP_OP_XWR_DP, `SPDP_OP_XWR_R0, `SPDP_OP_XWR_R1: state_reg <= ST_EXT_REQ;
              default: state_reg <= ST_IDLE;
            endcase
          end
        end
        ST_PUSH_INC: begin
          hold_reg  <= push_byte;
          state_reg <= ST_PUSH_WR;
        end
        ST_PUSH_WR: begin
          // Low byte first, then high byte
          if (is_pair(op) && !byte_reg) begin
            byte_reg  <= 1'b1;
            state_reg <= ST_PUSH_INC;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_POP: begin
          // High byte comes off first, reverse of the push
          if (is_pair(op) && !byte_reg) begin
            byte_reg <= 1'b1;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_DATA_ADDRESS_POINTER: begin
          if (wait_reg == 2'd0) begin
            state_reg <= ST_IDLE;
          end else begin
            wait_reg <= wait_reg - 2'd1;
          end
        end
        ST_EXT_REQ: begin
          if (ack_s2_reg) begin
            state_reg <= ST_EXT_REL;
          end
        end
        ST_EXT_REL: begin
          if (!ack_s2_reg) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Stack index: reset, software, push and pop
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_reg <= `SPDP_SP_RESET;
    end else if (wr_ok && ap_addr_reg == `SPDP_OFF_SP) begin
      sp_reg <= hwdata[7:0];
    end else if (state_reg == ST_PUSH_INC) begin
      sp_reg <= step(sp_reg, 1'b1);
    end else if (pop_to_sfr && dir == `SPDP_SFR_SP) begin
      sp_reg <= ram_rdata;
    end else if (state_reg == ST_POP) begin
      sp_reg <= step(sp_reg, 1'b0);
    end
  end

  // ----------------------------------------------------------------
  // Data pointer bytes
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dpl_reg <= `SPDP_BYTE_ZERO;
    end else if (wr_ok && ap_addr_reg == `SPDP_OFF_DPL) begin
      dpl_reg <= hwdata[7:0];
    end else if (pop_to_sfr && dir == `SPDP_SFR_DPL) begin
      dpl_reg <= ram_rdata;
    end else if (state_reg == ST_DATA_ADDRESS_POINTER && wait_reg == 2'd0) begin
      dpl_reg <= imm[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_reg <= `SPDP_BYTE_ZERO;
    end else if (wr_ok && ap_addr_reg == `SPDP_OFF_DPH) begin
      dph_reg <= hwdata[7:0];
    end else if (pop_to_sfr && dir == `SPDP_SFR_DPH) begin
      dph_reg <= ram_rdata;
    end else if (state_reg == ST_DATA_ADDRESS_POINTER && wait_reg == 2'd0) begin
      dph_reg <= imm[15:8];
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and index registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg <= `SPDP_BYTE_ZERO;
    end else if (wr_ok && ap_addr_reg == `SPDP_OFF_ACC) begin
      acc_reg <= hwdata[7:0];
    end else if (pop_to_sfr && dir == `SPDP_SFR_ACC) begin
      acc_reg <= ram_rdata;
    end else if (state_reg == ST_EXT_REQ && ack_s2_reg && !ext_we_reg) begin
      acc_reg <= rdat_s2_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r0_reg <= `SPDP_BYTE_ZERO;
      r1_reg <= `SPDP_BYTE_ZERO;
    end else begin
      if (wr_ok && ap_addr_reg == `SPDP_OFF_R0) begin
        r0_reg <= hwdata[7:0];
      end
      if (wr_ok && ap_addr_reg == `SPDP_OFF_R1) begin
        r1_reg <= hwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Command word, restored address and interrupt level
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_reg <= 32'h0000_0000;
    end else if (start) begin
      cmd_reg <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ret_reg <= 16'h0000;
    end else if (state_reg == ST_POP && is_pair(op)) begin
      if (!byte_reg) begin
        ret_reg[15:8] <= ram_rdata;
      end else begin
        ret_reg[7:0] <= ram_rdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      isr_reg <= 1'b0;
    end else if (start && new_op == `SPDP_OP_INT) begin
      isr_reg <= 1'b1;
    end else if (state_reg == ST_POP && op == `SPDP_OP_INTERRUPT_RETURN && byte_reg) begin
      isr_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // External data move handshake
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_addr_reg  <= 16'h0000;
      ext_wdata_reg <= `SPDP_BYTE_ZERO;
      ext_req_reg   <= 1'b0;
      ext_we_reg    <= 1'b0;
    end else if (state_reg == ST_IDLE && start && new_op >= `SPDP_OP_XRD_DP) begin
      unique case (new_op)
        `SPDP_OP_XRD_DP, `SPDP_OP_XWR_DP: ext_addr_reg <= data_address_pointer;
        `SPDP_OP_XRD_R0, `SPDP_OP_XWR_R0: ext_addr_reg <= {`SPDP_BYTE_ZERO, r0_reg};
        `SPDP_OP_XRD_R1, `SPDP_OP_XWR_R1: ext_addr_reg <= {`SPDP_BYTE_ZERO, r1_reg};
        default: ext_addr_reg <= ext_addr_reg;
      endcase
      ext_wdata_reg <= acc_reg;
      ext_we_reg    <= (new_op >= `SPDP_OP_XWR_DP) && (new_op <= `SPDP_OP_XWR_R1);
      ext_req_reg   <= (new_op <= `SPDP_OP_XWR_R1);
    end else if (state_reg == ST_EXT_REQ && ack_s2_reg) begin
      ext_req_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;

  // Register read view
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      `SPDP_OFF_CMD:  rd_mux = cmd_reg;
      `SPDP_OFF_STAT: begin
        rd_mux[`SPDP_STAT_BUSY] = (state_reg != ST_IDLE);
        rd_mux[`SPDP_STAT_ISR]  = isr_reg;
        rd_mux[`SPDP_STAT_XREQ] = ext_req_reg;
      end
      `SPDP_OFF_SP:   rd_mux[7:0]  = sp_reg;
      `SPDP_OFF_DPL:  rd_mux[7:0]  = dpl_reg;
      `SPDP_OFF_DPH:  rd_mux[7:0]  = dph_reg;
      `SPDP_OFF_ACC:  rd_mux[7:0]  = acc_reg;
      `SPDP_OFF_R0:   rd_mux[7:0]  = r0_reg;
      `SPDP_OFF_R1:   rd_mux[7:0]  = r1_reg;
      `SPDP_OFF_RET:  rd_mux[15:0] = ret_reg;
      default:        rd_mux = 32'h0000_0000;
    endcase
    if (haddr[31:8] != 24'h00_0000) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg   <= 1'b0;
      ap_addr_reg <= `SPDP_BYTE_ZERO;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      ap_wr_reg   <= ap_take && hwrite && (haddr[31:8] == 24'h00_0000);
      ap_addr_reg <= haddr[7:0];
      if (ap_take && !hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata    = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ext_addr  = ext_addr_reg;
  assign ext_wdata = ext_wdata_reg;
  assign ext_req   = ext_req_reg;
  assign ext_we    = ext_we_reg;

endmodule : spdp_core

// [dv/spdp_xram_model.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// External data RAM with four-phase handshake
// ----------------------------------------------------------------
module spdp_xram_model (
  input  wire logic        hclk,
  input  wire logic [15:0] ext_addr,
  input  wire logic [7:0]  ext_wdata,
  input  wire logic        ext_req,
  input  wire logic        ext_we,
  input  wire logic        slow,
  output spdp_pkg::spdp_byte_t ext_rdata,
  output logic             ext_ack
);
  import spdp_pkg::*;
  spdp_byte_t mem [0:65535]; // Full 64k space

  // Answer each request, promptly or after a stall
  initial begin
    ext_ack = 1'b0;
    ext_rdata = 8'ha5;
    forever begin
      @(posedge hclk);
      if (ext_req === 1'b1) begin
        repeat (slow ? 6 : 0) @(posedge hclk);
        if (ext_we) mem[ext_addr] <= ext_wdata;
        if (!ext_we) ext_rdata <= mem[ext_addr];
        @(posedge hclk);
        ext_ack <= 1'b1;
        do @(posedge hclk); while (ext_req === 1'b1);
        ext_ack <= 1'b0;
        ext_rdata <= ~ext_rdata; // Released, no stale byte
      end
    end
  end
endmodule : spdp_xram_model

// [dv/spdp_core_sva.sv]
`timescale 1ns/1ps
`include "spdp_params.svh"

// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module spdp_core_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [15:0] ext_addr,
  input wire logic [7:0]  ext_wdata,
  input wire logic        ext_req,
  input wire logic        ext_we,
  input wire spdp_pkg::spdp_byte_t ext_rdata,
  input wire logic        ext_ack
);
  import spdp_pkg::*;
  logic       cmd_dp_reg;
  logic [3:0] op_reg;
  wire take = hsel && htrans[1] && hready && hsize == `SPDP_HSIZE_WORD;
  wire [3:0] op = hwdata[3:0];
  wire ext_op = cmd_dp_reg && op >= `SPDP_OP_XRD_DP && op <= `SPDP_OP_XWR_R1;
  wire stk_op = cmd_dp_reg && op >= `SPDP_OP_PUSH && op <= `SPDP_OP_INTERRUPT_RETURN;
  wire r_form = op_reg inside {`SPDP_OP_XRD_R0, `SPDP_OP_XRD_R1,
                               `SPDP_OP_XWR_R0, `SPDP_OP_XWR_R1};

  // Track the opcode of the last command write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_dp_reg <= 1'b0;
      op_reg <= 4'h0;
    end else begin
      cmd_dp_reg <= take && hwrite && haddr == 32'h0;
      if (cmd_dp_reg) op_reg <= op;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_drop;
    ##[1:4] !ext_req;
  endsequence
  sequence s_start;
    ##[1:3] $rose(ext_req);
  endsequence

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
  a_hrdata_hold: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (take && !hwrite && haddr > 32'h20 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_req_hold: assert property (ext_req && !ext_ack |=> ext_req)
    else $error("request dropped before acknowledge");
  a_req_stable: assert property (ext_req && $past(ext_req) |->
    $stable(ext_addr) && $stable(ext_we) && $stable(ext_wdata))
    else $error("external address or data moved");
  a_ack_drop: assert property ($rose(ext_ack) |-> s_drop)
    else $error("request not released after acknowledge");
  a_ext_start: assert property (ext_op |-> s_start)
    else $error("external command gave no request");
  a_ext_dir: assert property ($rose(ext_req) |-> ext_we == (op_reg >= `SPDP_OP_XWR_DP))
    else $error("external direction wrong");
  a_r_page: assert property ($rose(ext_req) && r_form |-> ext_addr[15:8] == 8'h00)
    else $error("index form upper address not zero");
  a_stack_local: assert property (stk_op |=> !ext_req [*5])
    else $error("stack operation used external bus");
endmodule : spdp_core_sva

bind spdp_core spdp_core_sva i_spdp_core_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_req(ext_req), .ext_we(ext_we),
  .ext_rdata(ext_rdata), .ext_ack(ext_ack));

// [dv/testbench.sv]
`timescale 1ns/1ps
`include "spdp_params.svh"
`define TB_CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end

// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module testbench;
  import spdp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        ext_req, ext_we, ext_ack, slow, rd_dp_reg;
  logic [31:0] haddr, hwdata, hrdata, rdat, w;
  logic [31:0] seed = 32'hca13;
  logic [31:0] v [0:2];
  logic [15:0] a [0:2];
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] ext_addr;
  logic [7:0]  ext_wdata;
  logic [63:0] note;
  logic [63:0] note_q [$];
  string       name_q [$];
  spdp_byte_t  ext_rdata;
  int          n_fail, n_checks, i;
  assign hready = hreadyout;

  spdp_core i_spdp_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_req(ext_req), .ext_we(ext_we), .ext_rdata(ext_rdata),
    .ext_ack(ext_ack));
  spdp_xram_model i_spdp_xram_model (.hclk(hclk), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_req(ext_req), .ext_we(ext_we), .slow(slow),
    .ext_rdata(ext_rdata), .ext_ack(ext_ack));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // Address phase, held until ready
  task automatic aph(input logic [7:0] ad, input logic wr_en);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'b10;
    hwrite <= wr_en;
    hsize <= `SPDP_HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
  endtask : aph

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    aph(ad, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    @(posedge hclk);
  endtask : wr

  // Read; the expectation is noted for the monitor
  task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e,
                    input string nm);
    note_q.push_back({m, e & m});
    name_q.push_back(nm);
    aph(ad, 1'b0);
    do @(posedge hclk); while (hready !== 1'b1);
    rdat = hrdata;
  endtask : rd

  task automatic ck(input logic [7:0] ad, input logic [31:0] e, input string nm);
    rd(ad, 32'hffffffff, e, nm);
  endtask : ck

  task automatic cmd(input logic [3:0] op, input logic [7:0] dir, input logic [15:0] imm);
    wr(`SPDP_OFF_CMD, {imm, dir, 4'h0, op});
    do rd(`SPDP_OFF_STAT, 32'h0, 32'h0, "stat"); while (rdat[`SPDP_STAT_BUSY] !== 1'b0);
  endtask : cmd

  // Clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Monitor: compare each read data phase with the oldest note
  always @(posedge hclk) begin
    if (rd_dp_reg) begin
      note = note_q.pop_front();
      `TB_CHK(name_q.pop_front(), note[31:0], hrdata & note[63:32])
    end
    rd_dp_reg <= hsel && htrans[1] && !hwrite && hready;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata, hresetn, slow} = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ck(`SPDP_OFF_SP, 32'h07, "sp");
    ck(8'h24, 32'h0, "unmapped");
    for (i = 0; i < 3; i++) begin
      v[i] = xs();
      wr(`SPDP_OFF_ACC, v[i]);
      cmd(`SPDP_OP_PUSH, `SPDP_SFR_ACC, 16'h0);
      ck(`SPDP_OFF_SP, 32'h08 + i, "sp");
    end
    for (i = 2; i >= 0; i--) begin
      cmd(`SPDP_OP_POP, `SPDP_SFR_DPL, 16'h0);
      ck(`SPDP_OFF_DPL, v[i] & 32'hff, "pop");
      ck(`SPDP_OFF_SP, 32'h07 + i, "sp");
    end
    cmd(`SPDP_OP_PUSH, `SPDP_SFR_DPH, 16'h0);
    cmd(`SPDP_OP_POP, 8'h40, 16'h0);
    cmd(`SPDP_OP_PUSH, 8'h40, 16'h0);
    cmd(`SPDP_OP_POP, `SPDP_SFR_ACC, 16'h0);
    ck(`SPDP_OFF_ACC, 32'h0, "ram");
    for (i = 0; i < 2; i++) begin
      w = xs();
      cmd(i ? `SPDP_OP_INT : `SPDP_OP_CALL, 8'h00, w[15:0]);
      ck(`SPDP_OFF_SP, 32'h09, "sp");
      rd(`SPDP_OFF_STAT, 32'h2, i * 2, "isr");
      cmd(i ? `SPDP_OP_INTERRUPT_RETURN : `SPDP_OP_RET, 8'h00, 16'h0);
      ck(`SPDP_OFF_RET, w & 32'hffff, "ret");
      rd(`SPDP_OFF_STAT, 32'h2, 32'h0, "isr");
    end
    w = xs();
    cmd(`SPDP_OP_LDDP, 8'h00, w[15:0]);
    ck(`SPDP_OFF_DPH, w[15:8], "dph");
    wr(`SPDP_OFF_DPH, 32'h40);
    ck(`SPDP_OFF_DPL, w[7:0], "dpl");
    wr(`SPDP_OFF_R0, w[23:16]);
    wr(`SPDP_OFF_R1, w[23:16] ^ 8'h01);
    a[0] = {8'h40, w[7:0]};
    a[1] = {8'h00, w[23:16]};
    a[2] = {8'h00, w[23:16] ^ 8'h01};
    for (i = 0; i < 3; i++) begin
      v[i] = xs();
      slow = i[0];
      wr(`SPDP_OFF_ACC, v[i]);
      cmd(`SPDP_OP_XWR_DP + 4'(i), 8'h00, 16'h0);
      `TB_CHK("xram", v[i][7:0], i_spdp_xram_model.mem[a[i]])
    end
    for (i = 0; i < 3; i++) begin
      slow = !i[0];
      cmd(`SPDP_OP_XRD_DP + 4'(i), 8'h00, 16'h0);
      ck(`SPDP_OFF_ACC, v[i] & 32'hff, "acc");
    end
    wr(`SPDP_OFF_SP, 32'hff);
    cmd(`SPDP_OP_PUSH, `SPDP_SFR_ACC, 16'h0);
    ck(`SPDP_OFF_SP, 32'h00, "sp");
    cmd(`SPDP_OP_POP, `SPDP_SFR_DPL, 16'h0);
    ck(`SPDP_OFF_SP, 32'hff, "sp");
    repeat (2) @(posedge hclk);
    tally_and_finish();
  end
endmodule : testbench
